// [hdl/rsd_pkg.sv]
// Shared constants and types for the repeater status display block
package rsd_pkg;

  // Clock rate and derived cycle counts
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int FREEZE_MS     = 30;
  localparam int FREEZE_CYCLES_DFLT = FREEZE_MS * (CLK_HZ / 1000);
  localparam int FRZ_W         = 21;

  // Bus phase timing of one latch write, in ns, rounded up to whole cycles
  localparam int SETUP_NS      = 50;
  localparam int STROBE_NS     = 100;
  localparam int HOLD_NS       = 50;
  localparam logic [2:0] SETUP_CYC  = 3'((SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [2:0] STROBE_CYC = 3'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [2:0] HOLD_CYC   = 3'((HOLD_NS * CLK_MHZ + 999) / 1000);

  // Port count and bank extents
  localparam int NPORT         = 13;
  localparam logic [2:0] LOWER_LAST = 3'h7;
  localparam logic [2:0] UPPER_LAST = 3'h5;
  localparam int UPPER_BASE    = 7;

  // Data bus bit positions
  localparam int BIT_LINK      = 0;
  localparam int BIT_COL       = 1;
  localparam int BIT_REC       = 2;
  localparam int BIT_JAB_PART  = 3;
  localparam int BIT_POL       = 4;
  localparam int ADDR_LSB      = 5;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DISP   = 4'h8;

  // Reset values and bus responses
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} rsd_state_type;

endpackage : rsd_pkg

// [hdl/rsd_display.sv]
// Autonomous LED status display sequencer with AXI4-Lite control registers
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Autonomous display cycles, minimum or maximum mode
// - Mode bit captured at mode load
// - Bus bit 1 shows collision
// - Minimum: bit 2 any port receiving
// - Minimum: bit 3 shows jabber protect
// - Minimum: bit 4 any segment partitioned
// - Minimum: lower strobe loads, upper held high
// - Freeze display 30 ms after packet ends
// - Pause updates during periodic service interrupt
// - Maximum: bit 0 link of twisted-pair port
// - Maximum: bit 2 addressed port receiving
// - Maximum: bit 3 addressed port partitioned
// - Maximum: bit 4 reversed polarity, twisted-pair
// - Maximum: top three bits carry latch address
// - Lower strobe serves ports 1 to 7
// - Upper strobe serves ports 8 to 13
// - Lower address 0 aggregate, 1-7 ports
// - Upper addresses 0-5 are ports 8-13
// - Finish update before granting processor bus
module rsd_display
  import rsd_pkg::*;
#(
  parameter int FREEZE_CYCLES = FREEZE_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Repeater core status, same clock
  input  wire logic [NPORT-1:0]  port_col,
  input  wire logic [NPORT-1:0]  port_receive_flag,
  input  wire logic [NPORT-1:0]  port_part,
  input  wire logic [NPORT-1:0]  port_link,
  input  wire logic [NPORT-1:0]  reversed_polarity_flag,
  input  wire logic [NPORT-1:0]  port_twisted_pair,
  input  wire logic              jabber_protect_flag,
  input  wire logic              repeating,
  input  wire logic              periodic_service_interrupt,
  // Pins: mode load and processor strobes
  input  wire logic              mode_load,
  input  wire logic              mode_cfg_max,
  input  wire logic              proc_rd_n,
  input  wire logic              proc_wr_n,
  // Display bus and strobes
  output logic [7:0]             disp_data,
  output logic                   disp_data_oe,
  output logic                   lower_latch_strobe_n,
  output logic                   upper_latch_strobe_n,
  output logic                   bus_buffer_en_n
);

  typedef struct packed {
    logic [1:0]            rd_sync;
    logic [1:0]            wr_sync;
    logic [1:0]            ld_sync;
    logic [1:0]            cfg_sync;
    logic                  ld_prev;
    logic                  mode_max;
    logic                  enable;
    logic                  rep_prev;
    logic                  frozen;
    logic [FRZ_W-1:0]      frz_cnt;
    logic [NPORT-1:0]      s_col;
    logic [NPORT-1:0]      s_rec;
    logic [NPORT-1:0]      s_part;
    logic [NPORT-1:0]      s_link;
    logic [NPORT-1:0]      s_pol;
    logic                  s_jab;
    rsd_state_type         st;
    logic                  upper;
    logic [2:0]            addr;
    logic [2:0]            tcnt;
    logic [7:0]            dout;
    logic                  doe;
    logic                  str_lo_n;
    logic                  str_hi_n;
    logic                  buffen_n;
    logic                  awready;
    logic                  wready;
    logic                  aw_got;
    logic                  w_got;
    logic [3:0]            awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } rsd_regs_type;

  localparam logic [FRZ_W-1:0] FRZ_LOAD = FRZ_W'(FREEZE_CYCLES);

  rsd_regs_type r_r;
  rsd_regs_type r_nxt;

  // Status byte for one latch slot, built from the frozen-or-live snapshot and the live port_twisted_pair flags
  function automatic logic [7:0] slot_byte(input rsd_regs_type s, input logic mx,
                                           input logic up, input logic [2:0] a);
    logic [7:0] b;
    int         p;
    b = 8'h00;
    p = 0;
    if (!mx) begin
      b[BIT_COL]      = |s.s_col;
      b[BIT_REC]      = |s.s_rec;
      b[BIT_JAB_PART] = s.s_jab;
      b[BIT_POL]      = |s.s_part;
    end else begin
      b[7:ADDR_LSB] = a;
      if (!up && a == 3'h0) begin
        b[BIT_COL]      = |s.s_col;
        b[BIT_REC]      = |s.s_rec;
        b[BIT_JAB_PART] = s.s_jab;
      end else begin
        p = up ? UPPER_BASE + int'(a) : int'(a) - 1;
        b[BIT_COL]      = s.s_col[p];
        b[BIT_REC]      = s.s_rec[p];
        b[BIT_JAB_PART] = s.s_part[p];
        // Port 1 is the AUI port: no link or polarity
        if (p != 0) begin
          b[BIT_LINK] = s.s_link[p] & port_twisted_pair[p];
          b[BIT_POL]  = s.s_pol[p] & port_twisted_pair[p];
        end
      end
    end
    return b;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic proc_req;
    logic wr_fire;
    r_nxt = r_r;
    proc_req = 1'b0;
    wr_fire  = 1'b0;

    // Pin synchronisers; only the second stage is read below
    r_nxt.rd_sync  = {r_r.rd_sync[0], ~proc_rd_n};
    r_nxt.wr_sync  = {r_r.wr_sync[0], ~proc_wr_n};
    r_nxt.ld_sync  = {r_r.ld_sync[0], mode_load};
    r_nxt.cfg_sync = {r_r.cfg_sync[0], mode_cfg_max};
    r_nxt.ld_prev  = r_r.ld_sync[1];
    proc_req = r_r.rd_sync[1] | r_r.wr_sync[1];

    // Mode bit taken at the falling edge of the mode load pulse
    if (r_r.ld_prev && !r_r.ld_sync[1]) begin
      r_nxt.mode_max = r_r.cfg_sync[1];
    end

    // Freeze after a packet ends; a new packet or timeout releases it
    r_nxt.rep_prev = repeating;
    if (repeating && !r_r.rep_prev) begin
      r_nxt.frozen = 1'b0;
    end else if (!repeating && r_r.rep_prev) begin
      r_nxt.frozen  = 1'b1;
      r_nxt.frz_cnt = FRZ_LOAD;
    end else if (r_r.frozen) begin
      if (r_r.frz_cnt <= FRZ_W'(1)) begin
        r_nxt.frozen = 1'b0;
      end
      r_nxt.frz_cnt = r_r.frz_cnt - FRZ_W'(1);
    end

    // Snapshot follows live status unless frozen
    if (!r_nxt.frozen) begin
      r_nxt.s_col  = port_col;
      r_nxt.s_rec  = port_receive_flag;
      r_nxt.s_part = port_part;
      r_nxt.s_link = port_link;
      r_nxt.s_pol  = reversed_polarity_flag;
      r_nxt.s_jab  = jabber_protect_flag;
    end

    // Display sequencer; a slot in progress always runs to its end
    unique case (r_r.st)
      ST_IDLE: begin
        r_nxt.doe      = 1'b0;
        r_nxt.str_lo_n = 1'b1;
        r_nxt.str_hi_n = 1'b1;
        if (proc_req) begin
          r_nxt.buffen_n = 1'b0;
        end else begin
          r_nxt.buffen_n = 1'b1;
          if (r_r.enable && !periodic_service_interrupt) begin
            r_nxt.st   = ST_SETUP;
            r_nxt.doe  = 1'b1;
            r_nxt.dout = slot_byte(r_r, r_r.mode_max, r_r.upper, r_r.addr);
            r_nxt.tcnt = SETUP_CYC;
          end
        end
      end
      ST_SETUP: begin
        // Data has settled before the strobe falls
        if (r_r.tcnt <= 3'h1) begin
          r_nxt.st   = ST_STROBE;
          r_nxt.tcnt = STROBE_CYC;
          if (r_r.mode_max && r_r.upper) begin
            r_nxt.str_hi_n = 1'b0;
          end else begin
            r_nxt.str_lo_n = 1'b0;
          end
        end else begin
          r_nxt.tcnt = r_r.tcnt - 3'h1;
        end
      end
      ST_STROBE: begin
        if (r_r.tcnt <= 3'h1) begin
          r_nxt.st       = ST_HOLD;
          r_nxt.tcnt     = HOLD_CYC;
          r_nxt.str_lo_n = 1'b1;
          r_nxt.str_hi_n = 1'b1;
        end else begin
          r_nxt.tcnt = r_r.tcnt - 3'h1;
        end
      end
      ST_HOLD: begin
        // Data stays after the strobe rises, then step to the next slot
        if (r_r.tcnt <= 3'h1) begin
          r_nxt.st = ST_IDLE;
          if (!r_r.mode_max) begin
            r_nxt.upper = 1'b0;
            r_nxt.addr  = 3'h0;
          end else if (!r_r.upper) begin
            if (r_r.addr == LOWER_LAST) begin
              r_nxt.upper = 1'b1;
              r_nxt.addr  = 3'h0;
            end else begin
              r_nxt.addr = r_r.addr + 3'h1;
            end
          end else begin
            if (r_r.addr >= UPPER_LAST) begin
              r_nxt.upper = 1'b0;
              r_nxt.addr  = 3'h0;
            end else begin
              r_nxt.addr = r_r.addr + 3'h1;
            end
          end
        end else begin
          r_nxt.tcnt = r_r.tcnt - 3'h1;
        end
      end
    endcase

    // AXI write: address and data taken in either order
    if (s_axi_awvalid && r_r.awready) begin
      r_nxt.aw_got  = 1'b1;
      r_nxt.awready = 1'b0;
      r_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_r.wready) begin
      r_nxt.w_got  = 1'b1;
      r_nxt.wready = 1'b0;
      r_nxt.wdata  = s_axi_wdata;
      r_nxt.wstrb  = s_axi_wstrb;
    end
    wr_fire = r_r.aw_got && r_r.w_got && !r_r.bvalid;
    if (wr_fire) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got  = 1'b0;
      r_nxt.bvalid = 1'b1;
      if (r_r.awaddr == OFS_CTRL) begin
        r_nxt.bresp = RESP_OKAY;
        if (r_r.wstrb[0]) begin
          r_nxt.enable = r_r.wdata[0];
        end
      end else if (r_r.awaddr == OFS_STATUS || r_r.awaddr == OFS_DISP) begin
        r_nxt.bresp = RESP_OKAY;                         // Read-only, write ignored
      end else begin
        r_nxt.bresp = RESP_SLVERR;
      end
    end
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid  = 1'b0;
      r_nxt.awready = 1'b1;
      r_nxt.wready  = 1'b1;
    end

    // AXI read: one outstanding, answered the cycle after address is taken
    if (s_axi_arvalid && r_r.arready) begin
      r_nxt.arready = 1'b0;
      r_nxt.rvalid  = 1'b1;
      r_nxt.rresp   = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:   r_nxt.rdata = {31'h0000_0000, r_r.enable};
        OFS_STATUS: r_nxt.rdata = {24'h00_0000, r_r.upper, r_r.addr,
                                   ~r_r.buffen_n, r_r.st != ST_IDLE,
                                   r_r.frozen, r_r.mode_max};
        OFS_DISP:   r_nxt.rdata = {24'h00_0000, r_r.dout};
        default: begin
          r_nxt.rdata = 32'h0000_0000;
          r_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid  = 1'b0;
      r_nxt.arready = 1'b1;
    end
  end

  // State register; reset gives minimum mode, idle bus, strobes high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r          <= '0;
      r_r.st       <= ST_IDLE;
      r_r.enable   <= CTRL_EN_RST;
      r_r.str_lo_n <= 1'b1;
      r_r.str_hi_n <= 1'b1;
      r_r.buffen_n <= 1'b1;
      r_r.awready  <= 1'b1;
      r_r.wready   <= 1'b1;
      r_r.arready  <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready        = r_r.awready;
  assign s_axi_wready         = r_r.wready;
  assign s_axi_bvalid         = r_r.bvalid;
  assign s_axi_bresp          = r_r.bresp;
  assign s_axi_arready        = r_r.arready;
  assign s_axi_rvalid         = r_r.rvalid;
  assign s_axi_rdata          = r_r.rdata;
  assign s_axi_rresp          = r_r.rresp;
  assign disp_data            = r_r.dout;
  assign disp_data_oe         = r_r.doe;
  assign lower_latch_strobe_n = r_r.str_lo_n;
  assign upper_latch_strobe_n = r_r.str_hi_n;
  assign bus_buffer_en_n      = r_r.buffen_n;

endmodule // rsd_display

`default_nettype wire

// [sim/rsd_led_latches.sv]
// Behavioural model of the external LED latches on the display bus
`timescale 1ns/1ps
`default_nettype none
module rsd_led_latches (
  // Display bus from the block
  input wire logic [7:0] disp_data,
  input wire logic       lower_latch_strobe_n,
  input wire logic       upper_latch_strobe_n
);
  logic [7:0] min_q;
  logic [4:0] lower_q [8];
  logic [4:0] upper_q [8];
  int         lower_cnt = 0;
  int         upper_cnt = 0;

  // Capture on the trailing strobe edge, where the data is still held
  always @(posedge lower_latch_strobe_n) begin
    min_q <= disp_data;
    lower_q[disp_data[7:5]] <= disp_data[4:0];
    lower_cnt <= lower_cnt + 1;
  end

  // Upper bank, addresses 6 and 7 unused by the wiring
  always @(posedge upper_latch_strobe_n) begin
    upper_q[disp_data[7:5]] <= disp_data[4:0];
    upper_cnt <= upper_cnt + 1;
  end
endmodule // rsd_led_latches
`default_nettype wire

// [sim/rsd_display_checker.sv]
// Concurrent checks on the display sequencer ports
`timescale 1ns/1ps
`default_nettype none
module rsd_display_checker #(
  parameter int FREEZE_CYCLES = 20
) (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Register bus
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_awready,
  // Status and processor inputs
  input wire logic       periodic_service_interrupt,
  input wire logic       proc_rd_n,
  input wire logic       proc_wr_n,
  // Display bus
  input wire logic [7:0] disp_data,
  input wire logic       disp_data_oe,
  input wire logic       lower_latch_strobe_n,
  input wire logic       upper_latch_strobe_n,
  input wire logic       bus_buffer_en_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strobes_apart: assert property (lower_latch_strobe_n || upper_latch_strobe_n)
    else $error("both latch strobes low");
  a_strobe_width: assert property ($fell(lower_latch_strobe_n) |->
    !lower_latch_strobe_n [*4] ##1 lower_latch_strobe_n) else $error("lower strobe width");
  a_data_steady: assert property (!(lower_latch_strobe_n && upper_latch_strobe_n) |->
    $stable(disp_data) && disp_data_oe) else $error("display data moved under strobe");
  a_slot_shape: assert property ($rose(disp_data_oe) |->
    disp_data_oe [*8] ##1 (lower_latch_strobe_n && upper_latch_strobe_n && $stable(disp_data)))
    else $error("slot length wrong");
  a_setup_before: assert property ($rose(disp_data_oe) |->
    (lower_latch_strobe_n && upper_latch_strobe_n) [*2] ##1
    (!lower_latch_strobe_n || !upper_latch_strobe_n)) else $error("setup time wrong");
  a_grant_quiet: assert property (!bus_buffer_en_n |-> !disp_data_oe)
    else $error("bus driven while granted");
  a_grant_cause: assert property ($fell(bus_buffer_en_n) |-> !(proc_rd_n && proc_wr_n))
    else $error("grant without request");
  a_grant_soon: assert property ($fell(proc_rd_n && proc_wr_n) |-> ##[1:16] !bus_buffer_en_n)
    else $error("grant too late");
  a_irq_pause: assert property (periodic_service_interrupt &&
    $past(periodic_service_interrupt) && !disp_data_oe |=> !disp_data_oe)
    else $error("slot started during interrupt");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
endmodule // rsd_display_checker

bind rsd_display rsd_display_checker #(.FREEZE_CYCLES(FREEZE_CYCLES)) i_chk (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_awready, .periodic_service_interrupt, .proc_rd_n,
  .proc_wr_n, .disp_data, .disp_data_oe, .lower_latch_strobe_n, .upper_latch_strobe_n,
  .bus_buffer_en_n
);
`default_nettype wire

// [sim/rsd_display_tb.sv]
// Self-checking bench for the display sequencer
`timescale 1ns/1ps
`default_nettype none
module rsd_display_tb
  import rsd_pkg::*;
;
  localparam int FRZ = 300;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, repeating = 1'b0;
  logic jabber_protect_flag = 1'b0, periodic_service_interrupt = 1'b0, mode_load = 1'b0;
  logic mode_cfg_max = 1'b0, proc_rd_n = 1'b1, proc_wr_n = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [NPORT-1:0] port_col = '0, port_receive_flag = '0, port_part = '0, port_link = '0;
  logic [NPORT-1:0] reversed_polarity_flag = '0, port_twisted_pair = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, disp_data_oe;
  logic lower_latch_strobe_n, upper_latch_strobe_n, bus_buffer_en_n;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  disp_data;
  int          n_mismatch = 0;
  int          tests_run = 0;

  rsd_display #(.FREEZE_CYCLES(FRZ)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_col, .port_receive_flag, .port_part, .port_link, .reversed_polarity_flag,
    .port_twisted_pair, .jabber_protect_flag, .repeating, .periodic_service_interrupt,
    .mode_load, .mode_cfg_max, .proc_rd_n, .proc_wr_n, .disp_data, .disp_data_oe,
    .lower_latch_strobe_n, .upper_latch_strobe_n, .bus_buffer_en_n);
  rsd_led_latches i_led (.disp_data, .lower_latch_strobe_n, .upper_latch_strobe_n);

  // Free-running 40 MHz clock
  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // One register access; valids drop at the edge that takes them
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 200);
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n >= 200) begin
      n_mismatch++;
      stop_test();
    end
    @(posedge aclk);
  endtask

  // Latch contents the wiring should end up with in maximum mode
  function automatic logic [4:0] exp_lat(input logic up, input int a);
    int p;
    logic tp;
    p = up ? a + UPPER_BASE : a - 1;
    if (!up && a == 0) return {1'b0, jabber_protect_flag, |port_receive_flag, |port_col, 1'b0};
    tp = port_twisted_pair[p] && p != 0;
    return {reversed_polarity_flag[p] & tp, port_part[p], port_receive_flag[p], port_col[p],
            port_link[p] & tp};
  endfunction

  task automatic t_regs();
    logic [31:0] q;
    logic [1:0]  r;
    int          c;
    axi(1'b0, OFS_CTRL, 32'h0000_0000, q, r);
    chk(q, 32'h0000_0001);
    axi(1'b0, 4'hC, 32'h0000_0000, q, r);
    chk({q[29:0], r}, 32'(RESP_SLVERR));
    axi(1'b1, 4'hC, 32'h0000_0000, q, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi(1'b1, OFS_CTRL, 32'h0000_0000, q, r);
    cyc(12);
    c = i_led.lower_cnt;
    cyc(40);
    chk(32'(i_led.lower_cnt), 32'(c));
    axi(1'b1, OFS_CTRL, 32'h0000_0001, q, r);
  endtask

  task automatic t_min();
    logic [31:0] q;
    logic [1:0]  r;
    int          c;
    port_col <= 13'h0008;
    port_part <= 13'h1000;
    c = i_led.upper_cnt;
    cyc(40);
    chk(32'(i_led.min_q), 32'h0000_0012);
    port_receive_flag <= 13'h0004;
    jabber_protect_flag <= 1'b1;
    cyc(40);
    chk(32'(i_led.min_q), 32'h0000_001E);
    chk(32'(i_led.upper_cnt), 32'(c));
    // Last display byte is readable; status writes are ignored but accepted
    axi(1'b0, OFS_DISP, 32'h0000_0000, q, r);
    chk(q, 32'h0000_001E);
    axi(1'b1, OFS_STATUS, 32'h0000_0001, q, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  task automatic t_max();
    logic [31:0] q;
    logic [1:0]  r;
    port_col <= 13'h0005;
    port_receive_flag <= 13'h1010;
    port_part <= 13'h0102;
    port_link <= 13'h1FFF;
    reversed_polarity_flag <= 13'h0AAB;
    port_twisted_pair <= 13'h0FF1;
    mode_cfg_max <= 1'b1;
    mode_load <= 1'b1;
    cyc(6);
    mode_load <= 1'b0;
    cyc(300);
    for (int a = 0; a < 8; a++) chk(32'(i_led.lower_q[a]), 32'(exp_lat(1'b0, a)));
    for (int a = 0; a < 6; a++) chk(32'(i_led.upper_q[a]), 32'(exp_lat(1'b1, a)));
    axi(1'b0, OFS_STATUS, 32'h0000_0000, q, r);
    chk(32'(q[0]), 32'h0000_0001);
  endtask

  // Port 1 reception is snapshotted, then removed behind the freeze
  task automatic t_freeze(input logic early_end);
    port_receive_flag <= 13'h0001;
    repeating <= 1'b1;
    cyc(20);
    repeating <= 1'b0;
    cyc(3);
    port_receive_flag <= 13'h0000;
    cyc(20);
    repeating <= early_end;
    cyc(180);
    chk(32'(i_led.lower_q[1][BIT_REC]), 32'(!early_end));
    repeating <= 1'b0;
    cyc(400);
    chk(32'(i_led.lower_q[1][BIT_REC]), 32'h0000_0000);
  endtask

  task automatic t_irq();
    int c;
    periodic_service_interrupt <= 1'b1;
    cyc(12);
    c = i_led.lower_cnt + i_led.upper_cnt;
    cyc(60);
    chk(32'(i_led.lower_cnt + i_led.upper_cnt), 32'(c));
    periodic_service_interrupt <= 1'b0;
    cyc(30);
    chk(32'(i_led.lower_cnt + i_led.upper_cnt > c), 32'h0000_0001);
  endtask

  // Read strobe first, then write strobe
  task automatic t_proc();
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      if (k == 0) proc_rd_n <= 1'b0;
      else proc_wr_n <= 1'b0;
      do begin
        cyc(1);
        n++;
      end while (bus_buffer_en_n !== 1'b0 && n < 30);
      chk(32'(bus_buffer_en_n), 32'h0000_0000);
      if (n >= 30) stop_test();
      chk(32'(disp_data_oe), 32'h0000_0000);
      cyc(20);
      proc_rd_n <= 1'b1;
      proc_wr_n <= 1'b1;
      cyc(30);
      chk(32'(bus_buffer_en_n), 32'h0000_0001);
    end
  endtask

  // Overall limit on the run
  initial begin
    #2_000_000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    cyc(20);
    aresetn <= 1'b1;
    cyc(1);
    t_regs();
    t_min();
    t_max();
    t_freeze(1'b0);
    t_freeze(1'b1);
    t_irq();
    t_proc();
    stop_test();
  end
endmodule // rsd_display_tb
`default_nettype wire
